// ===== common/jsg_params.svh
// Constants for the JTAG security gate.
`ifndef JSG_PARAMS_SVH
`define JSG_PARAMS_SVH

`define JSG_CODE_W        128
`define JSG_OTP_BASE      32'hF000_0000
`define JSG_OTP_WORDS     4
`define JSG_KEY_RST       128'h0
`define JSG_FACTORY_DEF   {4{32'hFFFF_FFFF}}
`define JSG_TIEOFF_DEF    {4{32'h3C5A_96E1}}
`define JSG_IR_W          4
`define JSG_IR_EXTEST     4'h0
`define JSG_IR_SAMPLE     4'h1
`define JSG_IR_TEST       4'h4
`define JSG_IR_PORT_HI    2'h2
`define JSG_IR_BYPASS     4'hF
`define JSG_IR_CAPT       4'h1
`define JSG_KEY_PORT      2
`define JSG_PORTS_DEF     4
`define JSG_BSC_LEN_DEF   8

`endif

// ===== common/jsg_pkg.sv
// Types shared by the JTAG security gate.
package jsg_pkg;

   typedef enum logic [3:0] {
      JSG_TLR  = 4'h0,
      JSG_RTI  = 4'h1,
      JSG_SDR  = 4'h3,
      JSG_CDR  = 4'h2,
      JSG_SHDR = 4'h6,
      JSG_E1DR = 4'h7,
      JSG_PDR  = 4'h5,
      JSG_E2DR = 4'h4,
      JSG_UDR  = 4'hC,
      JSG_SIR  = 4'hD,
      JSG_CIR  = 4'hF,
      JSG_SHIR = 4'hE,
      JSG_E1IR = 4'hA,
      JSG_PIR  = 4'hB,
      JSG_E2IR = 4'h9,
      JSG_UIR  = 4'h8
   } jsg_tap_t;

   typedef enum logic [2:0] {
      JSG_PATH_BYP  = 3'h0,
      JSG_PATH_KEY  = 3'h1,
      JSG_PATH_BSC  = 3'h3,
      JSG_PATH_TEST = 3'h2,
      JSG_PATH_PORT = 3'h6
   } jsg_path_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic [31:0] data;
   } jsg_otp_wr_t;

   typedef struct packed {
      logic tms;
      logic tdi;
   } jsg_jtag_in_t;

endpackage

// ===== design/jsg_gate.sv
// JTAG security gate with test-port router and boundary-scan chain.
`timescale 1ns/1ps
`include "jsg_params.svh"
module jsg_gate
   import jsg_pkg::*;
#(
   parameter logic [`JSG_CODE_W-1:0] FACTORY = `JSG_FACTORY_DEF,
   parameter logic [`JSG_CODE_W-1:0] TIEOFF  = `JSG_TIEOFF_DEF,
   parameter int                     N_PORTS = `JSG_PORTS_DEF,
   parameter int                     BSC_LEN = `JSG_BSC_LEN_DEF
) (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_nrst,
   input  wire logic                   i_power_on_reset_n,
   input  wire jsg_otp_wr_t            i_otp_wr,
   input  wire logic                   i_tck,
   input  wire jsg_jtag_in_t           i_jtag,
   output logic                        o_tdo,
   output logic                        o_tdo_oe,
   output logic                        o_access_granted,
   output logic      [`JSG_CODE_W-1:0] o_visible_code,
   output logic      [N_PORTS-1:0]     o_port_en,
   output logic                        o_port_tdi,
   input  wire logic [N_PORTS-1:0]     i_port_tdo,
   output logic                        o_test_en,
   input  wire logic                   i_test_tdo,
   input  wire logic [BSC_LEN-1:0]     i_bsc_pin_in,
   output logic      [BSC_LEN-1:0]     o_bsc_pin_out,
   output logic                        o_bsc_extest
);

   localparam int CW = `JSG_CODE_W;
   localparam logic [CW-1:0] HIDDEN = FACTORY ^ TIEOFF;

   if (N_PORTS < `JSG_KEY_PORT + 1 || N_PORTS > 4) begin : g_chk_ports
      $error("jsg_gate serves three or four secondary ports only.");
   end
   if (BSC_LEN < 1) begin : g_chk_bsc
      $error("jsg_gate needs a boundary chain of at least one cell.");
   end
   if (FACTORY == '0) begin : g_chk_fac
      $error("jsg_gate factory code must not be all zeros.");
   end

   // System clock domain.

   logic          por_sys_n;
   logic          rst_sys_n;
   logic [CW-1:0] otp_code;
   logic [CW-1:0] key_q;
   logic [CW-1:0] mixed;
   logic          match;
   logic          code_valid;
   logic          granted_q;
   logic          upd_s;
   logic          upd_s_q;
   logic          key_load;

   // Link clock domain.

   logic                 por_tck_n;
   logic                 nrst_tck;
   logic                 rst_tck_n;
   logic                 gnt_tck;
   jsg_tap_t             tap_q;
   jsg_tap_t             tap_d;
   logic [`JSG_IR_W-1:0] ir_sr_q;
   logic [`JSG_IR_W-1:0] ir_q;
   jsg_path_t            path;
   logic [1:0]           port_idx;
   logic                 bypass_q;
   logic [CW-1:0]        key_sr_q;
   logic [CW-1:0]        key_hold_q;
   logic                 upd_tgl_q;
   logic [BSC_LEN-1:0]   bsc_pins_s;
   logic [BSC_LEN-1:0]   bsc_sr_q;
   logic [BSC_LEN-1:0]   bsc_upd_q;
   logic                 shift_dr;
   logic                 shift_ir;
   logic                 tdo_d;

   jsg_sync #(
      .WIDTH (1)
   ) u_por_sys (
      .i_clk   (i_clk_sys),
      .i_rst_n (1'b1),
      .i_d     (i_power_on_reset_n),
      .o_q     (por_sys_n)
   );

   assign rst_sys_n = i_nrst & por_sys_n;

   jsg_otp #(
      .FACTORY (FACTORY)
   ) u_otp (
      .i_clk_sys (i_clk_sys),
      .i_por_n   (por_sys_n),
      .i_wr      (i_otp_wr),
      .o_code    (otp_code)
   );

   assign o_visible_code = otp_code;

   // The key crosses as a held word announced by a toggle, so the wide
   // value is stable for two system clocks before it is taken.
   jsg_sync #(
      .WIDTH (1)
   ) u_upd_sys (
      .i_clk   (i_clk_sys),
      .i_rst_n (por_sys_n),
      .i_d     (upd_tgl_q),
      .o_q     (upd_s)
   );

   always_ff @(posedge i_clk_sys) begin
      if (!por_sys_n) begin
         upd_s_q <= 1'b0;
      end else begin
         upd_s_q <= upd_s;
      end
   end

   assign key_load = upd_s ^ upd_s_q;

   // The key register ignores the ordinary reset.
   always_ff @(posedge i_clk_sys) begin
      if (!por_sys_n) begin
         key_q <= `JSG_KEY_RST;
      end else if (key_load) begin
         key_q <= key_hold_q;
      end
   end

   assign mixed      = (otp_code ^ key_q) ^ TIEOFF;
   assign match      = (mixed == HIDDEN);
   assign code_valid = |otp_code;

   always_ff @(posedge i_clk_sys) begin
      if (!rst_sys_n) begin
         granted_q <= 1'b0;
      end else begin
         granted_q <= match & code_valid;
      end
   end

   assign o_access_granted = granted_q;

   // Resets, grant and boundary pins brought onto the link clock.

   jsg_sync #(
      .WIDTH (1)
   ) u_por_tck (
      .i_clk   (i_tck),
      .i_rst_n (1'b1),
      .i_d     (i_power_on_reset_n),
      .o_q     (por_tck_n)
   );

   jsg_sync #(
      .WIDTH (1)
   ) u_rst_tck (
      .i_clk   (i_tck),
      .i_rst_n (1'b1),
      .i_d     (i_nrst),
      .o_q     (nrst_tck)
   );

   assign rst_tck_n = nrst_tck & por_tck_n;

   jsg_sync #(
      .WIDTH (1)
   ) u_gnt_tck (
      .i_clk   (i_tck),
      .i_rst_n (rst_tck_n),
      .i_d     (granted_q),
      .o_q     (gnt_tck)
   );

   jsg_sync #(
      .WIDTH (BSC_LEN)
   ) u_pins (
      .i_clk   (i_tck),
      .i_rst_n (rst_tck_n),
      .i_d     (i_bsc_pin_in),
      .o_q     (bsc_pins_s)
   );

   // Test access port state machine.

   always_comb begin
      tap_d = tap_q;
      unique case (tap_q)
         JSG_TLR:  tap_d = i_jtag.tms ? JSG_TLR  : JSG_RTI;
         JSG_RTI:  tap_d = i_jtag.tms ? JSG_SDR  : JSG_RTI;
         JSG_SDR:  tap_d = i_jtag.tms ? JSG_SIR  : JSG_CDR;
         JSG_CDR:  tap_d = i_jtag.tms ? JSG_E1DR : JSG_SHDR;
         JSG_SHDR: tap_d = i_jtag.tms ? JSG_E1DR : JSG_SHDR;
         JSG_E1DR: tap_d = i_jtag.tms ? JSG_UDR  : JSG_PDR;
         JSG_PDR:  tap_d = i_jtag.tms ? JSG_E2DR : JSG_PDR;
         JSG_E2DR: tap_d = i_jtag.tms ? JSG_UDR  : JSG_SHDR;
         JSG_UDR:  tap_d = i_jtag.tms ? JSG_SDR  : JSG_RTI;
         JSG_SIR:  tap_d = i_jtag.tms ? JSG_TLR  : JSG_CIR;
         JSG_CIR:  tap_d = i_jtag.tms ? JSG_E1IR : JSG_SHIR;
         JSG_SHIR: tap_d = i_jtag.tms ? JSG_E1IR : JSG_SHIR;
         JSG_E1IR: tap_d = i_jtag.tms ? JSG_UIR  : JSG_PIR;
         JSG_PIR:  tap_d = i_jtag.tms ? JSG_E2IR : JSG_PIR;
         JSG_E2IR: tap_d = i_jtag.tms ? JSG_UIR  : JSG_SHIR;
         JSG_UIR:  tap_d = i_jtag.tms ? JSG_SDR  : JSG_RTI;
      endcase
   end

   always_ff @(posedge i_tck) begin
      if (!rst_tck_n) begin
         tap_q <= JSG_TLR;
      end else begin
         tap_q <= tap_d;
      end
   end

   assign shift_dr = (tap_q == JSG_SHDR);
   assign shift_ir = (tap_q == JSG_SHIR);

   // Instruction register.

   always_ff @(posedge i_tck) begin
      if (!rst_tck_n) begin
         ir_sr_q <= `JSG_IR_CAPT;
      end else if (tap_q == JSG_CIR) begin
         ir_sr_q <= `JSG_IR_CAPT;
      end else if (shift_ir) begin
         ir_sr_q <= {i_jtag.tdi, ir_sr_q[`JSG_IR_W-1:1]};
      end
   end

   always_ff @(posedge i_tck) begin
      if (!rst_tck_n || tap_q == JSG_TLR) begin
         ir_q <= `JSG_IR_BYPASS;
      end else if (tap_q == JSG_UIR) begin
         ir_q <= ir_sr_q;
      end
   end

   // Router: while locked only the key chain behind port 2 answers.

   assign port_idx = ir_q[1:0];

   always_comb begin
      path = JSG_PATH_BYP;
      if (ir_q[3:2] == `JSG_IR_PORT_HI) begin
         if (port_idx == 2'(`JSG_KEY_PORT)) begin
            path = JSG_PATH_KEY;
         end else if (gnt_tck && 32'(port_idx) < N_PORTS) begin
            path = JSG_PATH_PORT;
         end
      end else if (gnt_tck) begin
         if (ir_q == `JSG_IR_EXTEST || ir_q == `JSG_IR_SAMPLE) begin
            path = JSG_PATH_BSC;
         end else if (ir_q == `JSG_IR_TEST) begin
            path = JSG_PATH_TEST;
         end
      end
   end

   always_comb begin
      o_port_en = '0;
      for (int k = 0; k < N_PORTS; k++) begin
         if (path == JSG_PATH_PORT && 32'(port_idx) == k) begin
            o_port_en[k] = 1'b1;
         end
      end
   end

   assign o_test_en    = (path == JSG_PATH_TEST);
   assign o_port_tdi   = i_jtag.tdi;
   assign o_bsc_extest = (path == JSG_PATH_BSC) && (ir_q == `JSG_IR_EXTEST);

   // Bypass cell.

   always_ff @(posedge i_tck) begin
      if (!rst_tck_n || tap_q == JSG_CDR) begin
         bypass_q <= 1'b0;
      end else if (shift_dr) begin
         bypass_q <= i_jtag.tdi;
      end
   end

   // Key chain; capture reports the grant in bit zero.

   always_ff @(posedge i_tck) begin
      if (!rst_tck_n) begin
         key_sr_q <= '0;
      end else if (path == JSG_PATH_KEY && tap_q == JSG_CDR) begin
         key_sr_q <= {{(CW-1){1'b0}}, gnt_tck};
      end else if (path == JSG_PATH_KEY && shift_dr) begin
         key_sr_q <= {i_jtag.tdi, key_sr_q[CW-1:1]};
      end
   end

   always_ff @(posedge i_tck) begin
      if (!por_tck_n) begin
         key_hold_q <= `JSG_KEY_RST;
         upd_tgl_q  <= 1'b0;
      end else if (nrst_tck && path == JSG_PATH_KEY && tap_q == JSG_UDR) begin
         key_hold_q <= key_sr_q;
         upd_tgl_q  <= ~upd_tgl_q;
      end
   end

   // Boundary-scan chain.

   always_ff @(posedge i_tck) begin
      if (!rst_tck_n) begin
         bsc_sr_q <= '0;
      end else if (path == JSG_PATH_BSC && tap_q == JSG_CDR) begin
         bsc_sr_q <= bsc_pins_s;
      end else if (path == JSG_PATH_BSC && shift_dr) begin
         if (BSC_LEN == 1) begin
            bsc_sr_q[0] <= i_jtag.tdi;
         end else begin
            bsc_sr_q <= {i_jtag.tdi, bsc_sr_q[BSC_LEN-1:1]};
         end
      end
   end

   always_ff @(posedge i_tck) begin
      if (!rst_tck_n) begin
         bsc_upd_q <= '0;
      end else if (path == JSG_PATH_BSC && tap_q == JSG_UDR) begin
         bsc_upd_q <= bsc_sr_q;
      end
   end

   assign o_bsc_pin_out = bsc_upd_q;

   // Serial output, launched on the falling edge.

   always_comb begin
      tdo_d = 1'b0;
      if (shift_ir) begin
         tdo_d = ir_sr_q[0];
      end else if (shift_dr) begin
         unique case (path)
            JSG_PATH_BYP:  tdo_d = bypass_q;
            JSG_PATH_KEY:  tdo_d = key_sr_q[0];
            JSG_PATH_BSC:  tdo_d = bsc_sr_q[0];
            JSG_PATH_TEST: tdo_d = i_test_tdo;
            JSG_PATH_PORT: tdo_d = i_port_tdo[port_idx];
         endcase
      end
   end

   always_ff @(negedge i_tck) begin
      if (!rst_tck_n) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else begin
         o_tdo    <= tdo_d;
         o_tdo_oe <= shift_dr | shift_ir;
      end
   end

endmodule

// ===== design/jsg_otp.sv
// One-time-programmable store of the visible access code.
`timescale 1ns/1ps
`include "jsg_params.svh"
module jsg_otp
   import jsg_pkg::*;
#(
   parameter logic [`JSG_CODE_W-1:0] FACTORY = `JSG_FACTORY_DEF
) (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_por_n,
   input  wire jsg_otp_wr_t            i_wr,
   output logic      [`JSG_CODE_W-1:0] o_code
);

   localparam logic [31:0] BASE = `JSG_OTP_BASE;

   logic       hit;
   logic [1:0] word;

   assign hit  = i_wr.valid && (i_wr.addr[31:4] == BASE[31:4]) && (i_wr.addr[1:0] == 2'h0);
   assign word = i_wr.addr[3:2];

   always_ff @(posedge i_clk_sys) begin
      if (!i_por_n) begin
         o_code <= FACTORY;
      end else if (hit) begin
         o_code[word*32 +: 32] <= o_code[word*32 +: 32] & i_wr.data;
      end
   end

endmodule

// ===== design/jsg_sync.sv
// Two-flop level synchroniser.
`timescale 1ns/1ps
`include "jsg_params.svh"
module jsg_sync
   import jsg_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);

   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("jsg_sync needs WIDTH of at least one.");
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         o_q    <= '0;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end

endmodule

// ===== dv/jsg_gate_sva.sv
// Port checker for the JTAG security gate.
`timescale 1ns/1ps
`include "jsg_params.svh"
module jsg_gate_sva
   import jsg_pkg::*;
#(
   parameter logic [`JSG_CODE_W-1:0] FACTORY = `JSG_FACTORY_DEF,
   parameter int                     N_PORTS = `JSG_PORTS_DEF
) (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_nrst,
   input  wire logic                   i_power_on_reset_n,
   input  wire jsg_otp_wr_t            i_otp_wr,
   input  wire logic                   i_tck,
   input  wire logic                   o_access_granted,
   input  wire logic [`JSG_CODE_W-1:0] o_visible_code,
   input  wire logic [N_PORTS-1:0]     o_port_en,
   input  wire logic                   o_test_en,
   input  wire logic                   o_bsc_extest
);
   localparam logic [`JSG_CODE_W-1:0] ZERO = '0;
   logic [4:0] nrst_q;
   logic       hold_q;
   always_ff @(posedge i_clk_sys) begin
      nrst_q <= {nrst_q[3:0], i_nrst};
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_nrst && (&nrst_q)) begin
         hold_q <= o_access_granted;
      end
   end
   AST_PORT2: assert property (@(posedge i_tck) disable iff (!i_nrst)
      !o_port_en[`JSG_KEY_PORT]) else $error("key port enable raised");
   AST_SEC_PORTS: assert property (@(posedge i_tck) disable iff (!i_nrst)
      (!o_access_granted)[*4] |-> o_port_en == '0) else $error("port open while secured");
   AST_SEC_TEST: assert property (@(posedge i_tck) disable iff (!i_nrst)
      (!o_access_granted)[*4] |-> !o_test_en && !o_bsc_extest)
      else $error("test or boundary open while secured");
   AST_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      o_visible_code == ZERO |=> !o_access_granted) else $error("zero code granted");
   AST_POR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(i_power_on_reset_n) |-> ##[1:5] o_access_granted) else $error("no grant at power-on");
   AST_MONO: assert property (@(posedge i_clk_sys) disable iff (!i_power_on_reset_n)
      $past(i_power_on_reset_n) |-> (o_visible_code & ~$past(o_visible_code)) == ZERO)
      else $error("code bit rose");
   AST_WR: assert property (@(posedge i_clk_sys) disable iff (!i_power_on_reset_n)
      i_otp_wr.valid && i_otp_wr.addr == `JSG_OTP_BASE |=>
      o_visible_code[31:0] == ($past(o_visible_code[31:0]) & $past(i_otp_wr.data)))
      else $error("code word not programmed");
   AST_IGN: assert property (@(posedge i_clk_sys) disable iff (!i_power_on_reset_n)
      i_otp_wr.valid && (i_otp_wr.addr[31:4] != 28'hF00_0000 || i_otp_wr.addr[1:0] != 2'h0)
      |=> $stable(o_visible_code)) else $error("stray write changed code");
   AST_KEEP: assert property (@(posedge i_clk_sys) disable iff (!i_power_on_reset_n)
      $rose(i_nrst) && $past(i_power_on_reset_n) |-> ##4 o_access_granted == hold_q)
      else $error("system reset changed access");
   COV_GRANT: cover property (@(posedge i_clk_sys) $rose(o_access_granted));
   COV_PORT: cover property (@(posedge i_tck) o_port_en != '0);
   COV_EXTEST: cover property (@(posedge i_tck) o_bsc_extest);
endmodule
bind jsg_gate jsg_gate_sva #(.FACTORY(FACTORY), .N_PORTS(N_PORTS)) u_sva (.i_clk_sys,
   .i_nrst, .i_power_on_reset_n, .i_otp_wr, .i_tck, .o_access_granted, .o_visible_code,
   .o_port_en, .o_test_en, .o_bsc_extest);

// ===== dv/jsg_host.sv
// Behavioural JTAG host that clocks the link only inside frames.
`timescale 1ns/1ps
module jsg_host
   import jsg_pkg::*;
(
   output logic         o_tck,
   output jsg_jtag_in_t o_jtag,
   input  wire logic    i_tdo
);
   initial begin
      o_tck = 1'b0;
      o_jtag = '0;
   end
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      #2;
      o_jtag = '{tms: tms, tdi: tdi};
      #14;
      tdo = i_tdo;
      o_tck = 1'b1;
      #16;
      o_tck = 1'b0;
   endtask
   task automatic idle(input logic tms, input int n);
      logic t;
      repeat (n) step(tms, 1'b0, t);
   endtask
   // Runs Run-Test/Idle through one shift of n bits and back to Run-Test/Idle.
   task automatic scan(input logic ir, input int n, input logic [127:0] d,
                       output logic [127:0] q);
      logic t;
      q = '0;
      step(1'b1, 1'b0, t);
      if (ir) step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
      step(1'b0, 1'b0, t);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, d[i], t);
         q[i] = t;
      end
      step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
      o_jtag.tdi = ~o_jtag.tdi;
   endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the JTAG security gate.
`timescale 1ns/1ps
`include "jsg_params.svh"
module tb_top
   import jsg_pkg::*;
();
   localparam logic [127:0] FAC = `JSG_FACTORY_DEF;
   logic         clk = 1'b0;
   logic         nrst = 1'b0;
   logic         por_n = 1'b0;
   jsg_otp_wr_t  otp_wr = '0;
   logic         tck;
   jsg_jtag_in_t jtag;
   logic         tdo;
   logic         granted;
   logic [127:0] code;
   logic [3:0]   port_en;
   logic [3:0]   port_tdo = 4'h0;
   logic         test_en;
   logic         test_tdo = 1'b0;
   logic [7:0]   pin_in = 8'h00;
   logic [7:0]   pin_out;
   logic         extest;
   logic [127:0] m_code = FAC;
   logic [127:0] m_key = '0;
   logic [127:0] q;
   logic [127:0] d;
   int           n_fail = 0;
   int           check_count = 0;
   int           cyc = 0;
   int           seed = 32'h5240dc27;
   jsg_gate dut (
      .i_clk_sys(clk), .i_nrst(nrst), .i_power_on_reset_n(por_n), .i_otp_wr(otp_wr),
      .i_tck(tck), .i_jtag(jtag), .o_tdo(tdo), .o_tdo_oe(), .o_access_granted(granted),
      .o_visible_code(code), .o_port_en(port_en), .o_port_tdi(), .i_port_tdo(port_tdo),
      .o_test_en(test_en), .i_test_tdo(test_tdo), .i_bsc_pin_in(pin_in),
      .o_bsc_pin_out(pin_out), .o_bsc_extest(extest)
   );
   jsg_host h (.o_tck(tck), .o_jtag(jtag), .i_tdo(tdo));
   initial begin
      forever #12.5 clk = ~clk;
   end
   function automatic logic exp_g();
      return ((m_code ^ m_key) == FAC) && (m_code != '0);
   endfunction
   function automatic logic [5:0] exp_en(input int ir, input logic g);
      exp_en = 6'h00;
      if (g && ir == 0) exp_en[5] = 1'b1;
      if (g && ir == 4) exp_en[4] = 1'b1;
      if (g && ir >= 8 && ir <= 11 && ir != 10) exp_en[ir - 8] = 1'b1;
   endfunction
   // Bypass is a one-cell queue that starts at zero; open paths show their source.
   function automatic logic [7:0] exp_dr(input int ir, input logic g, input logic [7:0] din);
      logic fifo[$];
      exp_dr = 8'h00;
      fifo.push_back(1'b0);
      for (int b = 0; b < 8; b++) begin
         fifo.push_back(din[b]);
         exp_dr[b] = fifo.pop_front();
      end
      if (g && (ir == 0 || ir == 1)) exp_dr = pin_in;
      if (g && ir == 4) exp_dr = {8{test_tdo}};
      if (g && ir >= 8 && ir <= 11 && ir != 10) exp_dr = {8{port_tdo[ir - 8]}};
   endfunction
   task automatic chk_v(input logic [127:0] e, input logic [127:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_b(input logic e, input logic g);
      chk_v({127'h0, e}, {127'h0, g});
   endtask
   task automatic sys(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] dat);
      otp_wr = '{valid: 1'b1, addr: a, data: dat};
      sys(1);
      if (a[31:4] == 28'hF00_0000 && a[1:0] == 2'h0) m_code[a[3:2] * 32 +: 32] &= dat;
   endtask
   task automatic do_rst(input logic p);
      sys(1);
      nrst = 1'b0;
      if (p) por_n = 1'b0;
      h.idle(1'b1, 6);
      sys(1);
      nrst = 1'b1;
      por_n = 1'b1;
      if (p) m_key = '0;
      if (p) m_code = FAC;
      h.idle(1'b0, 4);
      sys(8);
   endtask
   task automatic run_irs(input string s);
      for (int i = 0; i < 16; i++) begin
         port_tdo = 4'($random(seed));
         test_tdo = 1'($random(seed));
         h.scan(1'b1, 4, 128'(i), q);
         chk_v(128'(exp_en(i, exp_g())), 128'({extest, test_en, port_en}));
         if (i != 10) begin
            d = 128'($random(seed));
            h.scan(1'b0, 8, d, q);
            chk_v(128'(exp_dr(i, exp_g(), d[7:0])), q);
         end
      end
      $display("test %s done", s);
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      do_rst(1'b1);
      chk_v(m_code, code);
      chk_b(exp_g(), granted);
      run_irs("factory");
      pin_in = 8'($random(seed));
      h.idle(1'b0, 3);
      h.scan(1'b1, 4, 128'h0, q);
      d = 128'($random(seed));
      h.scan(1'b0, 8, d, q);
      chk_v(128'(pin_in), q);
      chk_v(128'(d[7:0]), 128'(pin_out));
      $display("test boundary done");
      sys(1);
      wr(`JSG_OTP_BASE + 32'h4, 32'hFFFF_FFFE);
      wr(`JSG_OTP_BASE + 32'h4, 32'hFFFF_FFFF);
      wr(32'hF000_0010, $random(seed));
      wr(32'hF000_0002, $random(seed));
      otp_wr.valid = 1'b0;
      sys(4);
      chk_v(m_code, code);
      chk_b(exp_g(), granted);
      run_irs("secured");
      d = 128'($random(seed));
      h.scan(1'b1, 4, 128'hA, q);
      h.scan(1'b0, 128, d, q);
      chk_v(128'h0, q);
      m_key = d;
      sys(8);
      chk_b(exp_g(), granted);
      h.scan(1'b1, 4, 128'hA, q);
      h.scan(1'b0, 128, m_code ^ FAC, q);
      m_key = m_code ^ FAC;
      sys(8);
      chk_b(exp_g(), granted);
      $display("test key unlock done");
      run_irs("unlocked");
      do_rst(1'b0);
      chk_b(exp_g(), granted);
      $display("test system reset done");
      for (int w = 0; w < 4; w++) wr(`JSG_OTP_BASE + 32'(w * 4), 32'h0);
      otp_wr.valid = 1'b0;
      h.scan(1'b1, 4, 128'hA, q);
      h.scan(1'b0, 128, FAC, q);
      m_key = FAC;
      sys(8);
      chk_v(m_code, code);
      chk_b(exp_g(), granted);
      $display("test zero code done");
      do_rst(1'b1);
      chk_v(m_code, code);
      chk_b(exp_g(), granted);
      $display("test power-on done");
      final_report();
   end
endmodule
